/* logic/eitl_top.sv */
/*
  emergency input trigger logic: four inputs, edge triggers, emergency
  state with lamp, pin value messages, outputs and apb registers.
  assumes inputs asynchronous to pclk; button high when released.
*/
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module eitl_top #(
  parameter int HOLD_CYC = eitl_pkg::HOLD_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [eitl_pkg::N_IN-1:0]  pin_in,
  input  wire logic                       button_n,
  output logic      [eitl_pkg::N_OUT-1:0] pin_out,
  output logic                            lamp,
  output logic                            test_track,
  output logic                            pin_value_message,
  output logic      [eitl_pkg::N_IN-1:0]  pin_value,
  output logic                            report_pulse,
  output logic                            irq
);
  localparam int N = eitl_pkg::N_IN;
  ////////////////////////////////////////////////////////////////////////
  logic [17:0]                    cfg_ff;
  logic [eitl_pkg::N_OUT-1:0]     out_ff;
  logic [eitl_pkg::N_IRQ-1:0]     ist_ff;
  logic [eitl_pkg::N_IRQ-1:0]     imask_ff;
  logic [N-1:0]                   s1_ff;
  logic [N-1:0]                   s2_ff;
  logic [N-1:0]                   s3_ff;
  logic                           b1_ff;
  logic                           b2_ff;
  logic                           b3_ff;
  logic                           emerg_ff;
  logic                           test_ff;
  logic [31:0]                    hold_ff;
  logic [31:0]                    prdata_ff;
  logic                           pready_ff;
  logic                           msg_ff;
  logic [N-1:0]                   pv_ff;
  logic                           rep_ff;
  logic                           irq_ff;
  logic [N-1:0]                   trig;
  logic [N-1:0]                   is_emerg;
  logic [N-1:0]                   is_test;
  logic [N-1:0]                   is_gen;
  logic [N-1:0]                   act_lvl;
  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire        acc       = psel && penable && !pready_ff;
  wire        wr        = acc && pwrite;
  wire        wr_cfg    = wr && paddr == eitl_pkg::OFS_CFG;
  wire        wr_out    = wr && paddr == eitl_pkg::OFS_OUTPUT;
  wire        wr_rem    = wr && paddr == eitl_pkg::OFS_REMOTE;
  wire        wr_ist    = wr && paddr == eitl_pkg::OFS_IRQ_STAT;
  wire        wr_imask  = wr && paddr == eitl_pkg::OFS_IRQ_MASK;
  wire        hit       = paddr == eitl_pkg::OFS_CFG
                       || paddr == eitl_pkg::OFS_STATUS
                       || paddr == eitl_pkg::OFS_OUTPUT
                       || paddr == eitl_pkg::OFS_REMOTE
                       || paddr == eitl_pkg::OFS_IRQ_STAT
                       || paddr == eitl_pkg::OFS_IRQ_MASK
                       || paddr == eitl_pkg::OFS_PINS;
  wire        latch_md  = cfg_ff[eitl_pkg::CFG_SWTYPE]
                          == eitl_pkg::EITL_LATCH;
  wire        report_en = cfg_ff[eitl_pkg::CFG_REPORT];
  wire        clr_test  = wr && paddr == eitl_pkg::OFS_STATUS
                          && pwdata[eitl_pkg::ST_TEST];
  ////////////////////////////////////////////////////////////////////////
  // per-input edge triggers
  // button shares input zero: anded so a low on either looks like a low pin
  wire [N-1:0] lvl_cur = {s2_ff[N-1:1], s2_ff[0] & b2_ff};  // RULE13
  wire [N-1:0] lvl_old = {s3_ff[N-1:1], s3_ff[0] & b3_ff};  // RULE13
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_in
      eitl_pkg::eitl_incfg_t c;
      assign c = eitl_pkg::eitl_incfg_t'(cfg_ff[4*gi +: 4]);
      wire rise = lvl_cur[gi] & ~lvl_old[gi];
      wire fall = ~lvl_cur[gi] & lvl_old[gi];
      assign trig[gi]     = (rise & c.rise) | (fall & c.fall); // RULE12
      assign is_emerg[gi] = c.kind == eitl_pkg::EITL_EMERG;
      assign is_test[gi]  = c.kind == eitl_pkg::EITL_TEST;
      assign is_gen[gi]   = c.kind == eitl_pkg::EITL_GENERAL;
      // latching: condition present = level matching the enabled edge
      assign act_lvl[gi]  = is_emerg[gi]
                          & ((c.fall & ~lvl_cur[gi])
                          |  (c.rise &  lvl_cur[gi])); // RULE5
      AST_TRIG_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        fall && c.fall |-> trig[gi])
        else $error("enabled falling edge gave no trigger"); // RULE12
      AST_TRIG_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        rise && c.rise |-> trig[gi])
        else $error("enabled rising edge gave no trigger"); // RULE12
    end
  endgenerate
  wire emerg_trig = |(trig & is_emerg);
  wire test_trig  = |(trig & is_test);          // RULE10
  wire gen_trig   = |(trig & is_gen);           // RULE10
  wire pin_chg    = lvl_cur != lvl_old;
  // long press measured on the synchronised button and input zero lows
  wire pressed    = ~lvl_cur[0];
  wire hold_done  = hold_ff >= HOLD_CYC;        // RULE2
  ////////////////////////////////////////////////////////////////////////
  // emergency state
  logic nxt_emerg;
  always_comb begin
    nxt_emerg = emerg_ff;
    if (latch_md) begin
      nxt_emerg = |act_lvl;                     // RULE5 RULE6
    end else if (emerg_ff && hold_done) begin
      nxt_emerg = 1'b0;                         // RULE2
    end else if (!emerg_ff && emerg_trig) begin
      nxt_emerg = 1'b1;                         // RULE1
    end
  end
  wire [eitl_pkg::N_IRQ-1:0] ev = {test_trig, emerg_trig, gen_trig,
                                   pin_chg};
  wire [31:0] rd_mux =
      paddr == eitl_pkg::OFS_CFG      ? {14'h0000, cfg_ff} :
      paddr == eitl_pkg::OFS_STATUS   ? {30'h0, test_ff, emerg_ff} :
      paddr == eitl_pkg::OFS_OUTPUT   ? {29'h0, out_ff} :
      paddr == eitl_pkg::OFS_REMOTE   ? {29'h0, out_ff} :
      paddr == eitl_pkg::OFS_IRQ_STAT ? {28'h0, ist_ff} :
      paddr == eitl_pkg::OFS_IRQ_MASK ? {28'h0, imask_ff} :
      paddr == eitl_pkg::OFS_PINS     ? {28'h0, lvl_cur} : 32'h0;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '1;                              // RULE11
      s2_ff <= '1;
      s3_ff <= '1;
      b1_ff <= 1'b1;
      b2_ff <= 1'b1;
      b3_ff <= 1'b1;
    end else begin
      s1_ff <= pin_in;                          // RULE12
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      b1_ff <= button_n;
      b2_ff <= b1_ff;
      b3_ff <= b2_ff;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= eitl_pkg::CFG_RESET;            // RULE4 RULE9
    end else if (wr_cfg) begin
      cfg_ff <= pwdata[17:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= '0;
    end else if (wr_out || wr_rem) begin
      out_ff <= pwdata[eitl_pkg::N_OUT-1:0];    // RULE8
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 32'h0;
    end else if (!pressed || latch_md) begin
      hold_ff <= 32'h0;
    end else if (!hold_done) begin
      hold_ff <= hold_ff + 32'h1;               // RULE2
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emerg_ff <= 1'b0;
      test_ff  <= 1'b0;
    end else begin
      emerg_ff <= nxt_emerg;
      // test state stays until software clears its status bit
      if (test_trig) begin
        test_ff <= 1'b1;                        // RULE10
      end else if (clr_test) begin
        test_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff   <= '0;
      imask_ff <= '0;
    end else begin
      // a new event beats a simultaneous write-one clear
      ist_ff <= (ist_ff & ~(wr_ist ? pwdata[3:0] : 4'h0)) | ev;
      if (wr_imask) begin
        imask_ff <= pwdata[3:0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pslverr   <= 1'b0;
    end else begin
      pready_ff <= acc;
      prdata_ff <= rd_mux;
      pslverr   <= acc && !hit;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_ff    <= 1'b0;
      pv_ff     <= '1;
      rep_ff    <= 1'b0;
    end else begin
      msg_ff    <= report_en && pin_chg;        // RULE7
      pv_ff     <= lvl_cur;                     // RULE7
      rep_ff    <= gen_trig;                    // RULE10
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff    <= 1'b0;
      lamp      <= 1'b0;
    end else begin
      irq_ff    <= |(ist_ff & imask_ff);
      lamp      <= nxt_emerg;                   // RULE3
    end
  end
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pin_out           = out_ff;
  assign test_track        = test_ff;
  assign pin_value_message = msg_ff;
  assign pin_value         = pv_ff;
  assign report_pulse      = rep_ff;
  assign irq               = irq_ff;
  ////////////////////////////////////////////////////////////////////////
  AST_LAMP: assert property (@(posedge pclk) disable iff (!presetn)
    lamp == emerg_ff) else $error("lamp differs from emergency state"); // RULE3
  AST_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_md && !emerg_ff && emerg_trig |=> emerg_ff)
    else $error("momentary trigger did not enter emergency"); // RULE1
  AST_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_md && emerg_ff && hold_done |=> !emerg_ff)
    else $error("long press did not leave emergency"); // RULE2
  AST_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    latch_md |=> emerg_ff == $past(|act_lvl))
    else $error("latching state not following trigger level"); // RULE5
  AST_MSG: assert property (@(posedge pclk) disable iff (!presetn)
    report_en && pin_chg |=> pin_value_message && pin_value == $past(lvl_cur))
    else $error("pin change not reported"); // RULE7
  AST_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_out || wr_rem) |=> $stable(pin_out))
    else $error("outputs changed without a command"); // RULE8
  AST_TEST: assert property (@(posedge pclk) disable iff (!presetn)
    test_trig |=> test_track) else $error("test trigger lost"); // RULE10
  AST_GEN: assert property (@(posedge pclk) disable iff (!presetn)
    gen_trig |=> report_pulse) else $error("input report not queued"); // RULE10
  AST_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    trig[1] |-> lvl_cur[1] != lvl_old[1])
    else $error("trigger without an edge"); // RULE12
  ////////////////////////////////////////////////////////////////////////
  // bus side: one-cycle answer, registered read data and error
  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
    acc |=> pready)
    else $error("access not answered next cycle");
  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held over two cycles");
  AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  AST_NO_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
    acc && hit |=> !pslverr)
    else $error("error on a mapped address");
  AST_RD_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !hit |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CFG_WR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg |=> cfg_ff == $past(pwdata[17:0]))
    else $error("configuration write lost"); // RULE4
  AST_CFG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cfg |=> $stable(cfg_ff))
    else $error("configuration changed without a write"); // RULE4
  AST_OUT_WR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_out || wr_rem |=> pin_out == $past(pwdata[eitl_pkg::N_OUT-1:0]))
    else $error("output command not applied"); // RULE8
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq == $past(|(ist_ff & imask_ff)))
    else $error("interrupt level wrong");
  AST_IST_SET: assert property (@(posedge pclk) disable iff (!presetn)
    |ev |=> (ist_ff & $past(ev)) == $past(ev))
    else $error("event not recorded in status");
  AST_IST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ist && !(|ev) |=> (ist_ff & $past(pwdata[3:0])) == 4'h0)
    else $error("write-one did not clear status");
  AST_IMASK_WR: assert property (@(posedge pclk) disable iff (!presetn)
    wr_imask |=> imask_ff == $past(pwdata[3:0]))
    else $error("mask write lost");
  ////////////////////////////////////////////////////////////////////////
  // pin side: emergency, test and report behaviour
  AST_STAY: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_md && emerg_ff && !hold_done |=> emerg_ff)
    else $error("emergency left before long press"); // RULE2
  AST_NO_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_md && !emerg_ff && !emerg_trig |=> !emerg_ff)
    else $error("emergency entered without trigger"); // RULE1
  AST_HOLD_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    !pressed |=> hold_ff == 32'h0)
    else $error("hold count kept after release"); // RULE2
  AST_LATCH_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    latch_md && !(|act_lvl) |=> !lamp)
    else $error("latching emergency held without condition"); // RULE5
  AST_NO_MSG: assert property (@(posedge pclk) disable iff (!presetn)
    !(report_en && pin_chg) |=> !pin_value_message)
    else $error("pin message without a change"); // RULE7
  AST_REP_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    !gen_trig |=> !report_pulse)
    else $error("report without general trigger"); // RULE10
  AST_TEST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    test_track && !clr_test |=> test_track)
    else $error("test state lost without clear"); // RULE10
  AST_TEST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    clr_test && !test_trig |=> !test_track)
    else $error("test state not cleared"); // RULE10
  AST_SYNC0: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> s1_ff == $past(pin_in))
    else $error("first sync stage wrong"); // RULE12
  AST_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> s2_ff == $past(s1_ff))
    else $error("second sync stage wrong"); // RULE12
  AST_BUTTON: assert property (@(posedge pclk) disable iff (!presetn)
    !b2_ff |-> !lvl_cur[0])
    else $error("button press not seen on input zero"); // RULE13
  AST_STATUS_RD: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == eitl_pkg::OFS_STATUS
    |=> prdata[1:0] == $past({test_ff, emerg_ff}))
    else $error("status read wrong"); // RULE3
  AST_PINS_RD: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == eitl_pkg::OFS_PINS
    |=> prdata[3:0] == $past(lvl_cur))
    else $error("pin level read wrong"); // RULE11
endmodule

/* logic/eitl_pkg.sv */
/*
  constants, register map and types of the emergency input trigger logic.
  assumes a 32-bit apb slave at 100 mhz; used with package:: prefixes only.
*/
// Contract
// RULE1: momentary press and release enters emergency tracking
// RULE2: hold over three seconds leaves emergency tracking
// RULE3: lamp lit exactly while emergency tracking active
// RULE4: switch type momentary or latching, momentary default
// RULE5: latching mode follows trigger condition only
// RULE6: latching falling trigger: low enables, high disables
// RULE7: pin change with reporting on sends pin values
// RULE8: outputs set by command or remote, held
// RULE9: reset: input zero emergency, input one test
// RULE10: general trigger queues report; test enables test
// RULE11: inputs pulled up, idle reads high
// RULE12: synchronise inputs, detect edges, enabled directions
// RULE13: emergency button and input zero combined
package eitl_pkg;
  localparam int          N_IN          = 4;
  localparam int          N_OUT         = 3;
  // register byte offsets
  localparam logic [7:0]  OFS_CFG       = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_OUTPUT    = 8'h08;
  localparam logic [7:0]  OFS_REMOTE    = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0]  OFS_PINS      = 8'h18;
  // cfg fields: per input 4 bits {type[1:0], fall, rise} at 4*i
  localparam int          CFG_SWTYPE    = 16;
  localparam int          CFG_REPORT    = 17;
  // in0 emergency on fall (6), in1 test on fall (a), in2/in3 general off
  localparam logic [17:0] CFG_RESET     = 18'h000a6;
  // status fields
  localparam int          ST_EMERG      = 0;
  localparam int          ST_TEST       = 1;
  // irq bits
  localparam int          IRQ_PINCHG    = 0;
  localparam int          IRQ_GENERAL   = 1;
  localparam int          IRQ_EMERG     = 2;
  localparam int          IRQ_TEST      = 3;
  localparam int          N_IRQ         = 4;
  // timing
  localparam int          CLK_MHZ       = 100;
  localparam int          HOLD_MS       = 3000;
  localparam int          HOLD_CYC      = HOLD_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    EITL_GENERAL, EITL_EMERG, EITL_TEST, EITL_SPARE
  } eitl_type_t;
  typedef struct packed {
    eitl_type_t  kind;
    logic        fall;
    logic        rise;
  } eitl_incfg_t;
  typedef enum logic {EITL_MOMENT, EITL_LATCH} eitl_sw_t;
endpackage

/* bench/eitl_far_side.sv */
/*
  far-side model: switches and ttl sources on the four inputs plus
  the guarded button. assumes the bench moves drive_low/press on pclk.
*/
`timescale 1ns/100ps
module eitl_far_side (
  input  wire logic [3:0] drive_low,
  input  wire logic       press,
  output logic      [3:0] pin_in,
  output logic            button_n
);
  // open-collector sources: an undriven input floats to its pull-up
  assign pin_in   = ~drive_low;
  // button shares input zero, low while pressed
  assign button_n = ~press;
endmodule

/* bench/emergency_input_trigger_logic_tb.sv */
/*
  self-checking bench: apb tasks, pin stimulus and a counting model.
  assumes eitl_top with a short hold count and the far-side model.
*/
`timescale 1ns/100ps
module emergency_input_trigger_logic_tb;
  localparam int HOLD = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  drive_low, pin_in, pin_value, v, old;
  logic [2:0]  pin_out;
  logic        press, button_n, lamp, test_track, pv_msg, rep, irq, err;
  int          fail_count, comparisons, rep_n, rep_exp, seed;
  logic [3:0]  exp_q[$];

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  eitl_top #(.HOLD_CYC(HOLD)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .button_n(button_n), .pin_out(pin_out), .lamp(lamp),
    .test_track(test_track), .pin_value_message(pv_msg),
    .pin_value(pin_value), .report_pulse(rep), .irq(irq));
  eitl_far_side far (.drive_low(drive_low), .press(press),
    .pin_in(pin_in), .button_n(button_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) fail_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pins(input logic [3:0] lo, input logic p);
    @(posedge pclk);
    drive_low <= lo;
    press <= p;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // model side: count reports, match each pin message against the queue
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (rep === 1'b1) rep_n++;
      if (pv_msg === 1'b1) chk(pin_value, exp_q.size() ? exp_q.pop_front() : 4'hx);
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    conclude();
  end

  initial begin
    seed = 32'h3170d9d4;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {drive_low, press, presetn, fail_count, comparisons} = '0;
    {rep_n, rep_exp} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rg(eitl_pkg::OFS_CFG); chk(rd, 32'ha6);
    chk(rd[eitl_pkg::CFG_SWTYPE], 1'b0);
    rg(eitl_pkg::OFS_PINS); chk(rd, 32'hf);
    // brief button press enters, long low on input zero leaves
    pins(4'h0, 1'b1); cyc(5); pins(4'h0, 1'b0); cyc(8);
    chk(lamp, 1'b1);
    rg(eitl_pkg::OFS_STATUS); chk(rd[0], lamp);
    pins(4'h1, 1'b0); cyc(HOLD - 20); chk(lamp, 1'b1);
    cyc(40); chk(lamp, 1'b0);
    pins(4'h0, 1'b0); cyc(8); chk(lamp, 1'b0);
    wr(eitl_pkg::OFS_CFG, 32'h100a6);
    pins(4'h1, 1'b0); cyc(8); chk(lamp, 1'b1);
    pins(4'h0, 1'b0); cyc(8); chk(lamp, 1'b0);
    pins(4'h2, 1'b0); cyc(8); chk(test_track, 1'b1);
    pins(4'h0, 1'b0); cyc(4); wr(eitl_pkg::OFS_STATUS, 32'h2); cyc(2);
    chk(test_track, 1'b0);
    // in2 general on fall, in3 general on rise only
    wr(eitl_pkg::OFS_CFG, 32'h12a6); wr(eitl_pkg::OFS_IRQ_STAT, 32'hf);
    wr(eitl_pkg::OFS_IRQ_MASK, 32'h2); cyc(2); chk(irq, 1'b0);
    pins(4'h8, 1'b0); cyc(8); chk(rep_n, rep_exp);
    pins(4'hc, 1'b0); cyc(8); pins(4'h4, 1'b0); cyc(8); rep_exp += 2;
    chk(rep_n, rep_exp);
    chk(irq, 1'b1);
    wr(eitl_pkg::OFS_IRQ_STAT, 32'h2); cyc(3); chk(irq, 1'b0);
    pins(4'h0, 1'b0); cyc(8); old = 4'h0;
    wr(eitl_pkg::OFS_CFG, 32'h212a6);
    for (int k = 0; k < 8; k++) begin
      v = $random(seed) & 4'hc;
      if (v != old) exp_q.push_back(~v);
      // triggers on one edge make one report
      if ((!old[2] && v[2]) || (old[3] && !v[3])) rep_exp++;
      pins(v, 1'b0); cyc(10); old = v;
    end
    chk(rep_n, rep_exp); chk(exp_q.size(), 0);
    for (int k = 0; k < 2; k++) begin
      v = $random(seed);
      wr(eitl_pkg::OFS_OUTPUT, {29'h0, v[2:0]}); cyc(2);
      chk(pin_out, v[2:0]);
      wr(eitl_pkg::OFS_REMOTE, {29'h0, ~v[2:0]}); cyc(2);
      rg(eitl_pkg::OFS_OUTPUT); chk(rd, {29'h0, ~v[2:0]});
    end
    rg(8'h1c); chk(err, 1'b1); chk(rd, 32'h0);
    conclude();
  end
endmodule
